/* File: design/pria_device.sv */
`timescale 1ns/1ps
// What this block does
// - decode numbers 0x00..0xFF, 16-bit registers
// - page-select write steers later accesses
// - 0xF0 and 0xF1 same on all pages
// - pages 0, 1, 2 hold their control banks
// - indirect address/data pair on page 1
// - drivers: 5-bit id, byte offset, 1-2 bytes
// - address holds driver id and offset fields
// - mode 01 logical, else physical address
// - bit 15 set means 8-bit variable
// - data write stores to addressed location
// - data read returns addressed location
// - memory is 1K system plus 1K user
// - physical 0x400 reaches user memory
module pria_device #(
  parameter int PAGE_REGS = 256
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  pria_link_if.device      link,
  output logic [15:0]      pageSelect,
  output logic [15:0]      globalSpecial
);

  // per-page control banks; the indirect pair on page 1 shadows its slots
  logic [15:0] bankMem [pria_pkg::NUM_PAGES][PAGE_REGS];
  // microcontroller memory in two halves, byte wide so 8-bit variables need no merge
  logic [7:0]  sysMem  [pria_pkg::SYS_MEM_BYTES];
  logic [7:0]  userMem [pria_pkg::USER_MEM_BYTES];
  // index width inside one half; both halves are the same size
  localparam int HALF_AW = $clog2(pria_pkg::SYS_MEM_BYTES);

  logic [15:0] page_q;
  logic [15:0] page_d;
  logic [15:0] global_q;
  logic [15:0] global_d;
  logic [15:0] indAddr_q;
  logic [15:0] indAddr_d;
  logic        ack_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // decode of the incoming register number; clkEn low takes nothing, so all state holds
  // a request is taken once, on the edge where no answer is pending
  wire         take        = link.req & !ack_q & clkEn;
  wire         isPageSel   = link.addr == pria_pkg::PAGE_SELECT_NUM;
  wire         isGlobal    = link.addr == pria_pkg::GLOBAL_SPECIAL_NUM;
  wire         isUnpaged   = isPageSel | isGlobal;
  wire         onPage1     = page_q == pria_pkg::INDIRECT_PAGE;
  wire         isIndAddr   = onPage1 & (link.addr == pria_pkg::INDIRECT_ADDR_NUM);
  wire         isIndData   = onPage1 & (link.addr == pria_pkg::INDIRECT_DATA_NUM);
  wire         pageValid   = page_q < 16'(pria_pkg::NUM_PAGES);
  wire         regValid    = 32'(link.addr) < PAGE_REGS;
  wire         isBank      = !isUnpaged & !isIndAddr & !isIndData & pageValid & regValid;
  wire [1:0]   pageIdx     = page_q[1:0];

  // indirect address fields
  wire         size8       = indAddr_q[pria_pkg::IA_SIZE8_BIT];
  wire [1:0]   accMode     = indAddr_q[pria_pkg::IA_MODE_HI:pria_pkg::IA_MODE_LO];
  wire [4:0]   driverId    = indAddr_q[pria_pkg::IA_DRIVER_HI:pria_pkg::IA_DRIVER_LO];
  wire [7:0]   varOffset   = indAddr_q[pria_pkg::IA_OFFSET_HI:pria_pkg::IA_OFFSET_LO];
  wire         isLogical   = accMode == pria_pkg::MODE_LOGICAL;

  // the driver windows are a fixed layout of this model; real firmware keeps its own tables
  // logical: driver window base plus offset; physical: low address bits
  wire [10:0]  logAddr     = (11'(driverId) << pria_pkg::DRIVER_SHIFT) + 11'(varOffset);
  wire [10:0]  physAddr    = indAddr_q[pria_pkg::MEM_AW-1:0];
  wire [10:0]  memAddr     = isLogical ? logAddr : physAddr;
  // second byte wraps inside the 2K space rather than running off the end
  wire [10:0]  memAddrNext = memAddr + 11'h001;

  // the address bit above the half index picks system or user memory
  wire         firstUser   = memAddr >= pria_pkg::USER_MEM_BASE;
  wire         secondUser  = memAddrNext >= pria_pkg::USER_MEM_BASE;
  wire [HALF_AW-1:0] firstIdx  = memAddr[HALF_AW-1:0];
  wire [HALF_AW-1:0] secondIdx = memAddrNext[HALF_AW-1:0];

  // byte fetch from whichever half holds it; a word may straddle the halves
  wire [7:0]   firstByte   = firstUser ? userMem[firstIdx] : sysMem[firstIdx];
  wire [7:0]   secondByte  = secondUser ? userMem[secondIdx] : sysMem[secondIdx];

  // read value of the addressed location; 16-bit is high byte first
  wire [15:0]  memRead16   = {firstByte, secondByte};
  wire [15:0]  memRead8    = {8'h00, firstByte};
  wire [15:0]  memRead     = size8 ? memRead8 : memRead16;

  // read mux; anything not decoded answers zero
  wire [15:0]  bankRead    = isBank ? bankMem[pageIdx][link.addr] : pria_pkg::ZERO_WORD;
  wire [15:0]  specRead    = isPageSel ? page_q : global_q;
  wire [15:0]  indRead     = isIndAddr ? indAddr_q : memRead;

  always_comb begin
    if (isUnpaged) begin
      rdata_d = specRead;
    end else if (isIndAddr | isIndData) begin
      rdata_d = indRead;
    end else begin
      rdata_d = bankRead;
    end
  end

  // next values of the control registers
  wire         wrTake      = take & link.wr;
  always_comb begin
    page_d    = page_q;
    global_d  = global_q;
    indAddr_d = indAddr_q;
    if (wrTake & isPageSel) begin
      page_d = link.wdata;
    end
    if (wrTake & isGlobal) begin
      global_d = link.wdata;
    end
    if (wrTake & isIndAddr) begin
      indAddr_d = link.wdata;
    end
  end

  // page register; comes out of reset on the sensor page
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= pria_pkg::PAGE_RESET;
    end else if (clkEn) begin
      page_q <= page_d;
    end
  end

  // register above the page register, the same on every page
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_q <= pria_pkg::GLOBAL_RESET;
    end else if (clkEn) begin
      global_q <= global_d;
    end
  end

  // indirect address register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      indAddr_q <= pria_pkg::INDIRECT_RESET;
    end else if (clkEn) begin
      indAddr_q <= indAddr_d;
    end
  end

  // answer one cycle after the request, then drop so a held request acts once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else if (clkEn) begin
      ack_q <= take;
    end
  end

  // read data is loaded with the answer and then stands until the next read
  wire         rdTake      = take & !link.wr;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= pria_pkg::ZERO_WORD;
    end else if (rdTake) begin
      rdata_q <= rdata_d;
    end
  end

  // bank storage has no reset: the banks stand in for real control contents
  always_ff @(posedge sys_clk) begin
    if (wrTake & isBank & !ack_q) begin
      bankMem[pageIdx][link.addr] <= link.wdata;
    end
  end

  // microcontroller memory writes through the data register
  wire         memWrite    = wrTake & isIndData & !ack_q;
  // an 8-bit access writes only its one byte, taken from the low lane
  wire [7:0]   wrFirst     = size8 ? link.wdata[7:0] : link.wdata[15:8];
  wire [7:0]   wrSecond    = link.wdata[7:0];
  wire         wrSecondEn  = memWrite & !size8;
  wire         sysWrFirst  = memWrite & !firstUser;
  wire         sysWrSecond = wrSecondEn & !secondUser;
  wire         usrWrFirst  = memWrite & firstUser;
  wire         usrWrSecond = wrSecondEn & secondUser;

  // system half; the two bytes of one word never share an index
  always_ff @(posedge sys_clk) begin
    if (sysWrFirst) begin
      sysMem[firstIdx] <= wrFirst;
    end
    if (sysWrSecond) begin
      sysMem[secondIdx] <= wrSecond;
    end
  end

  // user half, where uploaded code lands
  always_ff @(posedge sys_clk) begin
    if (usrWrFirst) begin
      userMem[firstIdx] <= wrFirst;
    end
    if (usrWrSecond) begin
      userMem[secondIdx] <= wrSecond;
    end
  end

  assign link.ack      = ack_q;
  assign link.rdata    = rdata_q;
  assign pageSelect    = page_q;
  assign globalSpecial = global_q;

endmodule : pria_device

/* File: design/pria_pkg.sv */
package pria_pkg;
  // register numbers that sit outside the paging
  localparam logic [7:0]  PAGE_SELECT_NUM    = 8'hf0;
  localparam logic [7:0]  GLOBAL_SPECIAL_NUM = 8'hf1;
  // indirect access pair, page 1 only
  localparam logic [15:0] INDIRECT_PAGE      = 16'h0001;
  localparam logic [7:0]  INDIRECT_ADDR_NUM  = 8'hc6;
  localparam logic [7:0]  INDIRECT_DATA_NUM  = 8'hc8;
  // page numbers
  localparam logic [15:0] PAGE_SENSOR        = 16'h0000;
  localparam logic [15:0] PAGE_COLOUR        = 16'h0001;
  localparam logic [15:0] PAGE_JPEG          = 16'h0002;
  localparam int          NUM_PAGES          = 3;
  // reset values
  localparam logic [15:0] PAGE_RESET         = 16'h0000;
  localparam logic [15:0] GLOBAL_RESET       = 16'h0000;
  localparam logic [15:0] INDIRECT_RESET     = 16'h0000;
  // indirect address fields
  localparam int          IA_SIZE8_BIT       = 15;
  localparam int          IA_MODE_HI         = 14;
  localparam int          IA_MODE_LO         = 13;
  localparam int          IA_DRIVER_HI       = 12;
  localparam int          IA_DRIVER_LO       = 8;
  localparam int          IA_OFFSET_HI       = 7;
  localparam int          IA_OFFSET_LO       = 0;
  localparam logic [1:0]  MODE_LOGICAL       = 2'h1;
  // microcontroller memory: 1K system bytes then 1K user bytes
  localparam int          SYS_MEM_BYTES      = 1024;
  localparam int          USER_MEM_BYTES     = 1024;
  localparam int          MEM_BYTES          = SYS_MEM_BYTES + USER_MEM_BYTES;
  localparam int          MEM_AW             = 11;
  localparam logic [10:0] USER_MEM_BASE      = 11'h400;
  // logical variable placement: each driver owns a 32-byte window
  localparam int          DRIVER_SHIFT       = 5;
  localparam logic [15:0] ZERO_WORD          = 16'h0000;
endpackage : pria_pkg

/* File: design/pria_link_if.sv */
`timescale 1ns/1ps
// register access link between the host controller and the device
interface pria_link_if;
  logic        req;
  logic        wr;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;

  modport device (
    input  req,
    input  wr,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );

  modport host (
    output req,
    output wr,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface : pria_link_if

/* File: design/pria_host.sv */
`timescale 1ns/1ps
// host end: turns one user command into one link transaction
module pria_host (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdAddr,
  input  wire logic [15:0] cmdData,
  output logic             cmdBusy,
  output logic             cmdDone,
  output logic [15:0]      cmdRdata,
  pria_link_if.host        link
);

  typedef enum logic [0:0] {PRIA_IDLE, PRIA_WAIT} pria_state_t;

  pria_state_t state_q;
  logic        req_q;
  logic        wr_q;
  logic [7:0]  addr_q;
  logic [15:0] wdata_q;
  logic        done_q;
  logic [15:0] rdata_q;

  wire         start = (state_q == PRIA_IDLE) & cmdValid;
  wire         fin   = (state_q == PRIA_WAIT) & link.ack;

  // one outstanding request; a page write must finish before the next access
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PRIA_IDLE;
      req_q   <= 1'b0;
      wr_q    <= 1'b0;
      addr_q  <= 8'h00;
      wdata_q <= 16'h0000;
      done_q  <= 1'b0;
      rdata_q <= 16'h0000;
    end else if (clkEn) begin
      done_q <= 1'b0;
      case (state_q)
        PRIA_IDLE: begin
          if (start) begin
            req_q   <= 1'b1;
            wr_q    <= cmdWrite;
            addr_q  <= cmdAddr;
            wdata_q <= cmdData;
            state_q <= PRIA_WAIT;
          end
        end
        PRIA_WAIT: begin
          if (fin) begin
            req_q   <= 1'b0;
            done_q  <= 1'b1;
            rdata_q <= wr_q ? rdata_q : link.rdata;
            state_q <= PRIA_IDLE;
          end
        end
        default: state_q <= PRIA_IDLE;
      endcase
    end
  end

  assign link.req   = req_q;
  assign link.wr    = wr_q;
  assign link.addr  = addr_q;
  assign link.wdata = wdata_q;
  assign cmdBusy    = req_q;
  assign cmdDone    = done_q;
  assign cmdRdata   = rdata_q;

endmodule : pria_host

/* File: testbench/pria_link_props.sv */
`timescale 1ns/1ps
// link timing and unpaged register checks, seen from the wires alone
module pria_link_props (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] pageQ;
  logic [15:0] globQ;
  // decode of the answer cycle; addr is still held while ack is high
  wire         rdAns   = ack && !wr;
  wire         isPage  = addr == pria_pkg::PAGE_SELECT_NUM;
  wire         isGlob  = addr == pria_pkg::GLOBAL_SPECIAL_NUM;
  // shadows lag the device by a cycle, harmless as requests are spaced
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pageQ <= 16'h0000;
      globQ <= 16'h0000;
    end else if (ack && wr) begin
      pageQ <= isPage ? wdata : pageQ;
      globQ <= isGlob ? wdata : globQ;
    end
  end
  ack_one_cycle_a: assert property (req && !ack |=> ack)
    else $error("request not answered after one cycle");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  ack_cause_a: assert property (ack |-> $past(req) && !$past(ack))
    else $error("answer without a request");
  req_held_a: assert property (req && !ack |=> req && $stable(wr) && $stable(addr) && $stable(wdata))
    else $error("request changed before its answer");
  req_drop_a: assert property (ack |=> !req)
    else $error("request kept after answer");
  page_read_a: assert property (rdAns && isPage |-> rdata == pageQ)
    else $error("page select reads wrong value");
  global_read_a: assert property (rdAns && isGlob |-> rdata == globQ)
    else $error("unpaged register reads wrong value");
  unimpl_zero_a: assert property (
    rdAns && pageQ > pria_pkg::PAGE_JPEG && !isPage && !isGlob |-> rdata == 16'h0000)
    else $error("unimplemented page not read as zero");
  rdata_hold_a: assert property (!rdAns |-> $stable(rdata))
    else $error("read data moved without a read answer");
  cover property (rdAns && pageQ == 16'h0001 && addr == pria_pkg::INDIRECT_DATA_NUM);
  cover property (ack && wr && isPage);
  cover property (rdAns && pageQ == 16'h0003);
endmodule : pria_link_props

/* File: testbench/paged_register_indirect_access_bench.sv */
`timescale 1ns/1ps
// drives the host end's user side; the device answers across the link
module paged_register_indirect_access_bench;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clkEn = 1'b1;
  logic        cmdValid = 1'b0;
  logic        cmdWrite = 1'b0;
  logic [7:0]  cmdAddr = 8'h00;
  logic [15:0] cmdData = 16'h0000;
  logic        cmdBusy;
  logic        cmdDone;
  logic [15:0] cmdRdata;
  logic [15:0] pageSelect;
  logic [15:0] globalSpecial;
  int          errTotal = 0;
  int          comparisons = 0;
  pria_link_if link ();
  always #20 sys_clk = ~sys_clk;
  pria_device u_pria_device (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .link(link),
    .pageSelect(pageSelect), .globalSpecial(globalSpecial));
  pria_host u_pria_host (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdBusy(cmdBusy),
    .cmdDone(cmdDone), .cmdRdata(cmdRdata), .link(link));
  pria_link_props u_pria_link_props (.sys_clk(sys_clk), .rst_n(rst_n), .req(link.req),
    .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one command; valid drops once taken so it is never taken twice
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(negedge sys_clk);
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdAddr = a;
    cmdData = d;
    @(negedge sys_clk);
    cmdValid = 1'b0;
    chk({15'h0000, cmdBusy}, 16'h0001);
    n = 0;
    while (cmdDone !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk({15'h0000, cmdDone}, 16'h0001);
    chk({15'h0000, cmdBusy}, 16'h0000);
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk(cmdRdata, e);
  endtask : rd
  task automatic t_reset();
    rd(8'hf0, 16'h0000);
    rd(8'hf1, 16'h0000);
  endtask : t_reset
  // same numbers, lowest and highest, on each page must stay apart
  task automatic t_pages();
    for (int p = 0; p < 3; p++) begin
      acc(1'b1, 8'hf0, 16'(p));
      acc(1'b1, 8'h00, 16'h1000 + 16'(p));
      acc(1'b1, 8'hff, 16'h2000 + 16'(p));
    end
    for (int p = 2; p >= 0; p--) begin
      acc(1'b1, 8'hf0, 16'(p));
      rd(8'h00, 16'h1000 + 16'(p));
      rd(8'hff, 16'h2000 + 16'(p));
    end
  endtask : t_pages
  task automatic t_glob_unimpl();
    acc(1'b1, 8'hf1, 16'h5a5a);
    acc(1'b1, 8'hf0, 16'h0002);
    rd(8'hf1, 16'h5a5a);
    rd(8'hf0, 16'h0002);
    chk(pageSelect, 16'h0002);
    chk(globalSpecial, 16'h5a5a);
    acc(1'b1, 8'hf0, 16'h0003);
    acc(1'b1, 8'h00, 16'hbeef);
    rd(8'h00, 16'h0000);
    acc(1'b1, 8'hf0, 16'h0000);
    rd(8'h00, 16'h1000);
  endtask : t_glob_unimpl
  // indirect pair: physical, byte-wide, logical, and off page 1
  task automatic t_indirect();
    acc(1'b1, 8'hf0, 16'h0001);
    acc(1'b1, 8'hc6, 16'h0400);
    acc(1'b1, 8'hc8, 16'h1234);
    rd(8'hc8, 16'h1234);
    acc(1'b1, 8'hc6, 16'h8401);
    rd(8'hc8, 16'h0034);
    acc(1'b1, 8'hc6, 16'h03ff);
    acc(1'b1, 8'hc8, 16'habcd);
    acc(1'b1, 8'hc6, 16'h83ff);
    rd(8'hc8, 16'h00ab);
    acc(1'b1, 8'hc6, 16'h0400);
    rd(8'hc8, 16'hcd34);
    acc(1'b1, 8'hc6, 16'ha206);
    acc(1'b1, 8'hc8, 16'h0032);
    acc(1'b1, 8'hc6, 16'hc046);
    rd(8'hc8, 16'h0032);
    rd(8'hc6, 16'hc046);
    acc(1'b1, 8'hf0, 16'h0000);
    acc(1'b1, 8'hc6, 16'h1111);
    acc(1'b1, 8'hf0, 16'h0001);
    rd(8'hc6, 16'hc046);
  endtask : t_indirect
  // enable low: a waiting command is not taken and no register moves
  task automatic t_freeze();
    @(negedge sys_clk);
    clkEn = 1'b0;
    cmdValid = 1'b1;
    cmdWrite = 1'b1;
    cmdAddr = 8'hf1;
    cmdData = 16'h0f0f;
    repeat (3) @(negedge sys_clk);
    chk({15'h0000, cmdBusy}, 16'h0000);
    chk(globalSpecial, 16'h5a5a);
    cmdValid = 1'b0;
    clkEn = 1'b1;
    rd(8'hf1, 16'h5a5a);
  endtask : t_freeze
  // a reset in mid-run brings the page back to the sensor page
  task automatic t_rereset();
    acc(1'b1, 8'hf0, 16'h0002);
    chk(pageSelect, 16'h0002);
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    chk(pageSelect, 16'h0000);
    chk(globalSpecial, 16'h0000);
    rd(8'hf0, 16'h0000);
  endtask : t_rereset
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_pages();
    t_glob_unimpl();
    t_freeze();
    t_indirect();
    t_rereset();
    results();
  end
  // 53 commands of four cycles each; far more than that is a hang
  initial begin
    repeat (3000) @(posedge sys_clk);
    errTotal++;
    results();
  end
endmodule : paged_register_indirect_access_bench
